// File: src/fa_fault_ack.sv
// Fault acknowledgement with timed automatic retry, retry limit and lockout.
// Assumes pins arrive asynchronously and are synchronised here; the fault
// code and configuration come from logic on the same clock.
`timescale 1ns/1ns
module fa_fault_ack
	import fa_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = fa_pkg::SEC_CYCLES
) (
	input  wire logic                       sys_clk,        // 10 MHz clock.
	input  wire logic                       rstn,           // Power reset, low.
	input  wire logic [2:0]                 cfg_ack_src,    // Manual source.
	input  wire logic [fa_pkg::DLY_W-1:0]   cfg_auto_delay, // Seconds, 0 off.
	input  wire logic [fa_pkg::LIM_W-1:0]   cfg_ack_limit,  // 0 = unlimited.
	input  wire logic [3:0]                 din,            // Digital pins.
	input  wire logic                       key_ack,        // Keypad key pin.
	input  wire logic [1:0]                 ana_ack,        // Analogue compare.
	input  wire logic                       fault_in,       // Fault present pin.
	input  wire logic [fa_pkg::CODE_W-1:0]  fault_code_in,  // Cause of fault.
	input  wire logic                       motor_run,      // Current > 0.2 A.
	output logic                            fault_active,   // Drive tripped.
	output logic [fa_pkg::CODE_W-1:0]       fault_code,     // Held code.
	output logic                            lockout,        // Retry limit hit.
	output logic [fa_pkg::LIM_W-1:0]        ack_count,      // Auto acks done.
	output logic                            auto_ack,       // Auto clear pulse.
	output logic                            man_ack         // Manual pulse.
);
	import fa_pkg::*;

	if (TICK_CYCLES < 1) begin : g_bad_tick
		$error("fa_fault_ack needs a tick of at least one cycle");
	end

	// Field widths must cover the largest settings the store accepts,
	// and the span counter the largest limit times delay product.
	if (DLY_W < $clog2(DLY_MAX + 1)) begin : g_bad_dly
		$error("fa_fault_ack delay field too narrow");
	end
	if (LIM_W < $clog2(LIM_MAX + 1)) begin : g_bad_lim
		$error("fa_fault_ack limit field too narrow");
	end
	if (SPAN_W < $clog2(LIM_MAX * DLY_MAX + 1)) begin : g_bad_span
		$error("fa_fault_ack span counter too narrow");
	end

	// Two-flop synchronisers for every pin. Only the second stage feeds
	// logic; the reset value matches the idle level of every pin, so no
	// false edge or fault is seen as reset is released.
	logic [3:0] din_m, din_s;
	logic       key_m, key_s;
	logic [1:0] ana_m, ana_s;
	logic       flt_m, flt_s;
	logic       run_m, run_s;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			{din_m, key_m, ana_m, flt_m, run_m} <= '0;
			{din_s, key_s, ana_s, flt_s, run_s} <= '0;
		end else begin
			{din_m, key_m, ana_m, flt_m, run_m} <=
				{din, key_ack, ana_ack, fault_in, motor_run};
			{din_s, key_s, ana_s, flt_s, run_s} <=
				{din_m, key_m, ana_m, flt_m, run_m};
		end
	end

	// Manual source selection; only a rising edge counts as an ack.
	wire man_level =
		(cfg_ack_src == SRC_DIN1) ? din_s[0] :
		(cfg_ack_src == SRC_DIN2) ? din_s[1] :
		(cfg_ack_src == SRC_DIN3) ? din_s[2] :
		(cfg_ack_src == SRC_DIN4) ? din_s[3] :
		(cfg_ack_src == SRC_KEY)  ? key_s    :
		(cfg_ack_src == SRC_ANA1) ? ana_s[0] :
		(cfg_ack_src == SRC_ANA2) ? ana_s[1] : 1'b0;
	logic man_prev;
	wire  man_edge = man_level && !man_prev;

	// Edge memory; changing the source while the new input is high
	// may look like an edge, so reconfigure only while running.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			man_prev <= 1'b0;
		end else begin
			man_prev <= man_level;
		end
	end

	fa_state_e state, next_state;
	wire in_run   = (state == FA_RUN);
	wire in_fault = (state == FA_FAULT);
	wire enter_fault = in_run && flt_s;

	// Seconds for both the retry delay and the fault-free span.
	// The divider restarts on a trip so the first retry second is whole.
	logic sec_tick;
	fa_tick_div #(
		.CYCLES (TICK_CYCLES)
	) u_tick (
		.sys_clk (sys_clk),
		.rstn    (rstn),
		.restart (enter_fault),
		.tick    (sec_tick)
	);

	// Retry delay, saturating at the configured value. The count holds at
	// expiry so an attempt delayed by a lingering fault fires as soon as
	// the fault goes, rather than waiting another full delay.
	logic [DLY_W-1:0] dly_sec;
	wire auto_on  = (cfg_auto_delay != '0);
	wire dly_done = auto_on && (dly_sec >= cfg_auto_delay);

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			dly_sec <= '0;
		end else if (!in_fault) begin
			dly_sec <= '0;
		end else if (sec_tick && !dly_done) begin
			dly_sec <= dly_sec + 1'b1;
		end
	end

	// Attempt decisions. Lockout outranks a manual edge in the same cycle,
	// and a manual edge outranks the timer, so one clear is never counted
	// twice. A lockout attempt does not wait for the fault to go, while a
	// clearing attempt holds off until the fault condition has gone.
	wire limited   = (cfg_ack_limit != '0);
	wire exhausted = limited && (ack_count >= cfg_ack_limit);
	wire auto_try  = in_fault && dly_done;
	wire go_lock   = auto_try && exhausted;
	wire man_clear = in_fault && !go_lock && man_edge && !flt_s;
	wire auto_clr  = auto_try && !exhausted && !man_clear && !flt_s;

	// State sequence; the lockout state has no exit but reset, which here
	// stands for removing and restoring supply power.
	always_comb begin
		next_state = state;
		unique case (state)
			FA_RUN: begin
				if (flt_s) begin
					next_state = FA_FAULT;
				end
			end
			FA_FAULT: begin
				if (go_lock) begin
					next_state = FA_LOCK;
				end else if (man_clear || auto_clr) begin
					next_state = FA_RUN;
				end
			end
			FA_LOCK: begin
				next_state = FA_LOCK;
			end
			default: begin
				next_state = FA_LOCK;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state <= FA_RUN;
		end else begin
			state <= next_state;
		end
	end

	// Fault-free running time, only while the motor draws current.
	logic [SPAN_W-1:0] run_sec;
	wire [SPAN_W-1:0] span =
		SPAN_W'(cfg_ack_limit) * SPAN_W'(cfg_auto_delay);
	wire run_ok    = in_run && run_s && !flt_s;
	wire span_done = run_ok && (run_sec >= span);

	// A fault restarts the span; a stopped motor only pauses it. Once the
	// span is met the counter holds, so the count stays at zero for as
	// long as the motor keeps running without a fault.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			run_sec <= '0;
		end else if (!in_run || flt_s) begin
			run_sec <= '0;
		end else if (run_ok && sec_tick && !span_done) begin
			run_sec <= run_sec + 1'b1;
		end
	end

	// Next counter value; saturates so the unlimited mode cannot wrap.
	wire [LIM_W-1:0] next_count =
		span_done ? '0 :
		(auto_clr && ack_count != '1) ? ack_count + 1'b1 : ack_count;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ack_count <= '0;
		end else begin
			ack_count <= next_count;
		end
	end

	// Held fault code: captured on trip, replaced on lockout. The cause
	// line is only trusted at the edge where the trip is taken.
	wire [CODE_W-1:0] next_code =
		(next_state == FA_LOCK) ? CODE_LOCKED :
		enter_fault ? fault_code_in :
		(next_state == FA_RUN) ? CODE_NONE : fault_code;

	// Outputs are registered copies of the decisions made above, so every
	// pulse lasts exactly one cycle and lines up with the new state.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			fault_code   <= CODE_NONE;
			fault_active <= 1'b0;
			lockout      <= 1'b0;
			auto_ack     <= 1'b0;
			man_ack      <= 1'b0;
		end else begin
			fault_code   <= next_code;
			fault_active <= (next_state != FA_RUN);
			lockout      <= (next_state == FA_LOCK);
			auto_ack     <= auto_clr;
			man_ack      <= man_clear;
		end
	end
endmodule

// File: src/fa_pkg.sv
// Constants shared by the fault acknowledgement logic and its tick divider.
// Assumes a single 10 MHz system clock and configuration held steady by
// the surrounding parameter store.
// Notes on behaviour
// - A nonzero auto delay clears a pending fault after that many seconds, zero disables it, range up to 1000000, default 0.
// - The chosen manual acknowledgement source stays live while automatic acknowledgement is also enabled.
// - Automatic acknowledgements are limited to a count of up to 500, default 5, where zero means no limit.
// - Automatic acknowledgements are counted and the count returns to zero after fault-free running for limit times delay seconds.
// - That fault-free time only advances while motor current is above 0.2 A and no fault is present.
// - Once the allowed automatic acknowledgements are used up, the next automatic attempt raises fault code 22 instead of clearing.
// - The code 22 lockout ignores every acknowledgement and only a power cycle removes it.
package fa_pkg;

	// Clock and one-second tick.
	localparam int unsigned CLK_HZ     = 10_000_000;
	localparam int unsigned SEC_TIME_S = 1;
	localparam int unsigned SEC_CYCLES = SEC_TIME_S * CLK_HZ;

	// Automatic acknowledgement delay in seconds.
	localparam int unsigned DLY_W       = 20;
	localparam int unsigned DLY_MAX     = 1_000_000;
	localparam logic [19:0] DLY_DEFAULT = 20'h00000;

	// Limit of automatic acknowledgements.
	localparam int unsigned LIM_W       = 9;
	localparam int unsigned LIM_MAX     = 500;
	localparam logic [8:0]  LIM_DEFAULT = 9'h005;

	// Fault-free running span, limit times delay, fits 29 bits.
	localparam int unsigned SPAN_W = 29;

	// Fault codes.
	localparam int unsigned CODE_W      = 8;
	localparam logic [7:0]  CODE_NONE   = 8'h00;
	localparam logic [7:0]  CODE_LOCKED = 8'h16;

	// Manual acknowledgement source selections.
	localparam logic [2:0] SRC_NONE    = 3'h0;
	localparam logic [2:0] SRC_DIN1    = 3'h1;
	localparam logic [2:0] SRC_DIN2    = 3'h2;
	localparam logic [2:0] SRC_DIN3    = 3'h3;
	localparam logic [2:0] SRC_DIN4    = 3'h4;
	localparam logic [2:0] SRC_KEY     = 3'h5;
	localparam logic [2:0] SRC_ANA1    = 3'h6;
	localparam logic [2:0] SRC_ANA2    = 3'h7;
	localparam logic [2:0] SRC_DEFAULT = 3'h3;

	// Acknowledgement states.
	typedef enum logic [2:0] {
		FA_RUN   = 3'b001,
		FA_FAULT = 3'b010,
		FA_LOCK  = 3'b100
	} fa_state_e;

endpackage

// File: src/fa_tick_div.sv
// One-second tick divider for the fault acknowledgement logic.
// Assumes one clock; the tick is a one-cycle enable, not a clock.
`timescale 1ns/1ns
module fa_tick_div #(
	parameter int unsigned CYCLES = fa_pkg::SEC_CYCLES
) (
	input  wire logic sys_clk,  // System clock.
	input  wire logic rstn,     // Asynchronous reset, active low.
	input  wire logic restart,  // Restart the second from zero.
	output logic      tick      // One-cycle pulse each second.
);
	localparam int unsigned CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

	logic [CW-1:0] cnt;
	wire           wrap = (cnt == LAST);

	if (CYCLES < 1) begin : g_bad
		$error("fa_tick_div needs at least one cycle per tick");
	end

	// Restart aligns the first tick to a full second after a fault.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			cnt  <= '0;
			tick <= 1'b0;
		end else begin
			cnt  <= (restart || wrap) ? '0 : cnt + 1'b1;
			tick <= wrap && !restart;
		end
	end
endmodule

// File: tb/fa_drive_model.sv
// Drive-side model: fault source and motor current qualifier.
// Assumes bench commands arrive on the same clock.
`timescale 1ns/1ns
module fa_drive_model (
	input  wire logic  sys_clk,              // Clock.
	input  wire logic  trip,                 // Ask for a fault.
	input  wire logic  run,                  // Ask for motor current.
	output logic       fault_in = 1'b0,      // Fault present.
	output logic [7:0] fault_code_in = 8'h00, // Fault cause.
	output logic       motor_run = 1'b0      // Current above 0.2 A.
);
	// The fault vanishes with its cause and the stage stops in a fault,
	// so the code line toggles whenever no fault qualifies it.
	always @(posedge sys_clk) begin
		fault_in <= trip;
		motor_run <= run & ~trip;
		fault_code_in <= trip ? 8'h05 : ~fault_code_in;
	end
endmodule

// File: tb/fa_fault_ack_chk.sv
// Port checker for the fault acknowledgement block.
// Assumes a bind onto fa_fault_ack and a retry limit held steady.
`timescale 1ns/1ns
module fa_chk
	import fa_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = 10
) (
	input wire logic        sys_clk,        // Clock.
	input wire logic        rstn,           // Reset, active low.
	input wire logic [19:0] cfg_auto_delay, // Auto delay.
	input wire logic [8:0]  cfg_ack_limit,  // Retry limit.
	input wire logic        fault_active,   // Tripped.
	input wire logic [7:0]  fault_code,     // Held code.
	input wire logic        lockout,        // Locked.
	input wire logic [8:0]  ack_count,      // Auto acks done.
	input wire logic        auto_ack,       // Auto pulse.
	input wire logic        man_ack         // Manual pulse.
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	// Lockout must survive every acknowledgement until power returns.
	a_lock_holds: assert property (lockout |=> lockout[*4])
		else $error("lockout dropped");
	a_lock_quiet: assert property (
		lockout |-> !auto_ack && !man_ack)
		else $error("ack pulse in lockout");
	a_lock_code: assert property (
		lockout |-> fault_active && fault_code == CODE_LOCKED)
		else $error("lockout without code");
	a_lock_entry: assert property (
		$rose(lockout) |-> cfg_ack_limit != 9'h000 &&
			ack_count >= cfg_ack_limit)
		else $error("lockout before limit");
	a_auto_clears: assert property (
		auto_ack |-> !fault_active && fault_code == CODE_NONE)
		else $error("auto ack left fault");
	a_delay_off: assert property (
		cfg_auto_delay == 20'h00000 |-> !auto_ack)
		else $error("auto ack while off");
	a_limit_kept: assert property (
		cfg_ack_limit != 9'h000 |-> ack_count <= cfg_ack_limit)
		else $error("count above limit");
	a_auto_counts: assert property (
		auto_ack |-> ack_count == $past(ack_count) + 9'h001)
		else $error("auto ack not counted");
	a_man_keeps: assert property (
		man_ack |-> ack_count == $past(ack_count))
		else $error("manual ack counted");
	a_clear_idle: assert property (
		ack_count == 9'h000 && $past(ack_count) != 9'h000 |->
			!$past(fault_active))
		else $error("count cleared in fault");

	// Main scenarios seen at least once.
	c_auto: cover property (auto_ack);
	c_man: cover property (man_ack);
	c_lock: cover property ($rose(lockout));
endmodule

bind fa_fault_ack fa_chk #(.TICK_CYCLES(TICK_CYCLES)) chk_u (
	.sys_clk(sys_clk), .rstn(rstn), .cfg_auto_delay(cfg_auto_delay),
	.cfg_ack_limit(cfg_ack_limit), .fault_active(fault_active),
	.fault_code(fault_code), .lockout(lockout), .ack_count(ack_count),
	.auto_ack(auto_ack), .man_ack(man_ack));

// File: tb/fa_fault_ack_test.sv
// Self-checking bench for the fault acknowledgement block.
// Assumes a ten-cycle second, delays of 2 s (1000 s in the manual test, 0 in the off test) and a retry limit of 2,
// later lifted to test the unlimited setting.
`timescale 1ns/1ns
module fa_fault_ack_test;
	import fa_pkg::*;
	logic        sys_clk = 1'b0;
	logic        rstn = 1'b0;
	logic [2:0]  src = 3'h0;
	logic [19:0] dly = 20'h00000;
	logic [8:0]  lim = 9'h002;
	logic [3:0]  din = 4'h0;
	logic        key = 1'b0;
	logic [1:0]  ana = 2'h0;
	logic        trip = 1'b0;
	logic        run = 1'b0;
	wire logic   flt, mrun, act, lck, aack, mack;
	wire logic [7:0] fcin, code;
	wire logic [8:0] cnt;
	int          n_fail = 0, checked = 0, n_auto = 0, n_man = 0;

	fa_drive_model drv_u (.sys_clk(sys_clk), .trip(trip), .run(run),
		.fault_in(flt), .fault_code_in(fcin), .motor_run(mrun));
	fa_fault_ack #(.TICK_CYCLES(10)) dut_u (.sys_clk(sys_clk),
		.rstn(rstn), .cfg_ack_src(src), .cfg_auto_delay(dly),
		.cfg_ack_limit(lim), .din(din), .key_ack(key), .ana_ack(ana),
		.fault_in(flt), .fault_code_in(fcin), .motor_run(mrun),
		.fault_active(act), .fault_code(code), .lockout(lck),
		.ack_count(cnt), .auto_ack(aack), .man_ack(mack));

	// Clock, and pulse counters read before the edge's updates land.
	initial forever #50 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		if (aack === 1'b1) n_auto++;
		if (mack === 1'b1) n_man++;
	end

	task cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task results();
		if (n_fail == 0 && checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task trip_pulse();
		@(posedge sys_clk) trip <= 1'b1;
		cyc(6);
		trip <= 1'b0;
		cyc(4);
	endtask
	// Only the selected line moves (every line when the source is 0), so a wrong selection stays visible.
	task press(input logic v);
		logic [7:0] m;
		m = (src == 3'h0) ? 8'hfe : 8'h01 << src;
		@(posedge sys_clk);
		din <= m[4:1] & {4{v}};
		key <= m[5] & v;
		ana <= m[7:6] & {2{v}};
		cyc(5);
	endtask
	task power();
		@(posedge sys_clk) rstn <= 1'b0;
		cyc(4);
		rstn <= 1'b1;
		cyc(2);
		@(negedge sys_clk) chk({act, lck, code, cnt}, 0);
	endtask
	task t_manual();
		@(posedge sys_clk) dly <= 20'h003e8;
		for (int s = 0; s < 8; s++) begin
			@(posedge sys_clk) src <= s[2:0];
			trip <= 1'b1;
			cyc(4);
			press(1'b1);
			press(1'b0);
			@(negedge sys_clk) chk(act, 1);
			chk(code, 8'h05);
			@(posedge sys_clk) trip <= 1'b0;
			cyc(4);
			press(1'b1);
			press(1'b0);
			@(negedge sys_clk) chk(n_man, s);
			chk(act, s == 0);
		end
		chk(cnt, 0);
	endtask
	task t_clear();
		@(posedge sys_clk) dly <= 20'h00002;
		trip_pulse();
		@(negedge sys_clk) chk(n_auto, 0);
		cyc(30);
		@(negedge sys_clk) chk(cnt, 1);
		cyc(60);
		@(negedge sys_clk) chk(cnt, 1);
		@(posedge sys_clk) run <= 1'b1;
		cyc(30);
		@(negedge sys_clk) chk(cnt, 1);
		cyc(25);
		@(negedge sys_clk) chk(cnt, 0);
		@(posedge sys_clk) run <= 1'b0;
	endtask
	task t_lock();
		for (int i = 0; i < 3; i++) begin
			trip_pulse();
			cyc(30);
			@(negedge sys_clk) chk(cnt, (i < 2) ? i + 1 : 2);
			chk(lck, i == 2);
		end
		chk(code, 8'h16);
		chk(n_auto, 3);
		@(posedge sys_clk) src <= 3'h1;
		run <= 1'b1;
		press(1'b1);
		press(1'b0);
		cyc(60);
		@(negedge sys_clk) chk({lck, code}, 9'h116);
		chk(n_man, 7);
		@(posedge sys_clk) run <= 1'b0;
		power();
	endtask
	// With no limit the count runs past two and no lockout follows.
	task t_unlim();
		@(posedge sys_clk) lim <= 9'h000;
		for (int i = 0; i < 3; i++) begin
			trip_pulse();
			cyc(30);
			@(negedge sys_clk) chk(cnt, i + 1);
			chk(lck, 0);
		end
		chk(n_auto, 6);
	endtask
	task t_off();
		@(posedge sys_clk) dly <= 20'h00000;
		trip_pulse();
		cyc(60);
		@(negedge sys_clk) chk(act, 1);
		chk(n_auto, 6);
	endtask

	// Main sequence after the power-on reset.
	initial begin
		cyc(4);
		rstn <= 1'b1;
		cyc(2);
		t_manual();
		t_clear();
		t_lock();
		t_unlim();
		t_off();
		results();
	end
	// A hang counts as a mismatch; the run needs under 100 us.
	initial begin
		#500000;
		n_fail++;
		results();
	end
endmodule
